// *** include/gpio_pin_consts.svh ***
// Constants for the general-purpose pin port: offsets, fields, reset values
// Summary of operation
// - A pin is general-purpose only while its enable bit is 1.
// - Enabled pin with direction bit 0 is an input, driver off.
// - Enabled pin with direction bit 1 is an output and is driven.
// - Direction bit has no effect while the pin's enable bit is clear.
// - Enable register: bit x for pin x, 15..0; upper bits read zero.
// - Reset sets enable bits for pins 0 and 3..7; others clear.
// - Direction register: bit x for pin x, 15..0; upper bits read zero.
// - Reset clears all direction bits; every pin starts as input.
`ifndef GPIO_PIN_CONSTS_SVH
`define GPIO_PIN_CONSTS_SVH

`define PIN_COUNT            16
`define PIN_ENABLE_OFFSET    32'h01b0_0000
`define PIN_DIRECTION_OFFSET 32'h01b0_0004
`define PIN_DATA_OUT_OFFSET  32'h01b0_0008
`define PIN_DATA_IN_OFFSET   32'h01b0_000c
`define PIN_ENABLE_RESET     16'h00f9
`define PIN_DIRECTION_RESET  16'h0000
`define PIN_DATA_OUT_RESET   16'h0000
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// *** include/gpio_pin_pkg.sv ***
// Types shared by the general-purpose pin port
`default_nettype none
package gpio_pin_pkg;
  typedef logic [15:0] pin_vec_t;
endpackage
`default_nettype wire

// *** core/general_purpose_pin_port.sv ***
// General-purpose pin port with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_consts.svh"

module general_purpose_pin_port
  import gpio_pin_pkg::*;
(
  input  wire logic        mclk,          // 40 MHz clock
  input  wire logic        resetn,        // Async reset, active low
  input  wire logic [31:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [31:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic [15:0] general_pins_in,  // Pin levels
  output logic      [15:0] general_pins_out, // Pin drive values
  output logic      [15:0] general_pins_oe_n,// Drive enable, low drives
  output logic      [15:0] pin_gp_mode      // High: pin owned by this block
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pin_vec_t    pin_enable_r, pin_enable_nxt;
  pin_vec_t    pin_direction_r, pin_direction_nxt;
  pin_vec_t    pin_data_out_r, pin_data_out_nxt;
  logic        aw_held_r, aw_held_nxt;
  logic [31:0] aw_addr_r, aw_addr_nxt;
  logic        w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  pin_vec_t    gp_mode_r, gp_mode_nxt;
  pin_vec_t    pins_oe_n_r, pins_oe_n_nxt;
  pin_vec_t    pins_out_r, pins_out_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Registers sit on word boundaries, so the byte-offset bits are dropped
  function automatic logic [31:0] word_addr(input logic [31:0] a);
    return {a[31:2], 2'b00};
  endfunction

  // Only byte lanes 0 and 1 hold bits; lanes 2 and 3 are reserved
  function automatic pin_vec_t merge_strb(input pin_vec_t old_v, input logic [31:0] d,
                                          input logic [3:0] strb);
    pin_vec_t v;
    v = old_v;
    if (strb[0]) v[7:0] = d[7:0];
    if (strb[1]) v[15:8] = d[15:8];
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic do_write;
  // Refuse new requests while the answer still waits to be taken
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    aw_held_nxt       = aw_held_r;
    aw_addr_nxt       = aw_addr_r;
    w_held_nxt        = w_held_r;
    w_data_nxt        = w_data_r;
    w_strb_nxt        = w_strb_r;
    bvalid_nxt        = bvalid_r;
    bresp_nxt         = bresp_r;
    pin_enable_nxt    = pin_enable_r;
    pin_direction_nxt = pin_direction_r;
    pin_data_out_nxt  = pin_data_out_r;
    // Address and data may come in either order; each waits here for the other
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `AXI_RESP_OKAY;
      // Upper bits are reserved, so only the low two lanes land
      case (word_addr(aw_addr_r))
        `PIN_ENABLE_OFFSET:    pin_enable_nxt = merge_strb(pin_enable_r, w_data_r, w_strb_r);
        `PIN_DIRECTION_OFFSET: pin_direction_nxt = merge_strb(pin_direction_r, w_data_r, w_strb_r);
        `PIN_DATA_OUT_OFFSET:  pin_data_out_nxt = merge_strb(pin_data_out_r, w_data_r, w_strb_r);
        // Input levels are read-only: the write is accepted and dropped
        `PIN_DATA_IN_OFFSET:   bresp_nxt = `AXI_RESP_OKAY;
        default:               bresp_nxt = `AXI_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r       <= 1'b0;
      aw_addr_r       <= 32'h0000_0000;
      w_held_r        <= 1'b0;
      w_data_r        <= 32'h0000_0000;
      w_strb_r        <= 4'h0;
      bvalid_r        <= 1'b0;
      bresp_r         <= `AXI_RESP_OKAY;
      pin_enable_r    <= `PIN_ENABLE_RESET;
      pin_direction_r <= `PIN_DIRECTION_RESET;
      pin_data_out_r  <= `PIN_DATA_OUT_RESET;
    end else begin
      aw_held_r       <= aw_held_nxt;
      aw_addr_r       <= aw_addr_nxt;
      w_held_r        <= w_held_nxt;
      w_data_r        <= w_data_nxt;
      w_strb_r        <= w_strb_nxt;
      bvalid_r        <= bvalid_nxt;
      bresp_r         <= bresp_nxt;
      pin_enable_r    <= pin_enable_nxt;
      pin_direction_r <= pin_direction_nxt;
      pin_data_out_r  <= pin_data_out_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `AXI_RESP_OKAY;
      // Pins are sampled once, on the address edge, and held for the answer
      case (word_addr(s_axi_araddr))
        `PIN_ENABLE_OFFSET:    rdata_nxt = {16'h0000, pin_enable_r};
        `PIN_DIRECTION_OFFSET: rdata_nxt = {16'h0000, pin_direction_r};
        `PIN_DATA_OUT_OFFSET:  rdata_nxt = {16'h0000, pin_data_out_r};
        `PIN_DATA_IN_OFFSET:   rdata_nxt = {16'h0000, general_pins_in};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `AXI_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `AXI_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else begin
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ---------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------
  // Direction is gated by enable, so a disabled pin never drives
  // Built from the next register values: pins move on the write edge itself
  always_comb begin
    gp_mode_nxt   = pin_enable_nxt;
    pins_oe_n_nxt = ~(pin_enable_nxt & pin_direction_nxt);
    pins_out_nxt  = pin_data_out_nxt & pin_enable_nxt;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gp_mode_r   <= `PIN_ENABLE_RESET;
      pins_oe_n_r <= ~(`PIN_ENABLE_RESET & `PIN_DIRECTION_RESET);
      pins_out_r  <= `PIN_DATA_OUT_RESET & `PIN_ENABLE_RESET;
    end else begin
      gp_mode_r   <= gp_mode_nxt;
      pins_oe_n_r <= pins_oe_n_nxt;
      pins_out_r  <= pins_out_nxt;
    end
  end

  // Pad-side outputs come straight from flip-flops
  assign pin_gp_mode       = gp_mode_r;
  assign general_pins_oe_n = pins_oe_n_r;
  assign general_pins_out  = pins_out_r;

endmodule // general_purpose_pin_port

`default_nettype wire

// *** verification/gpio_pin_port_properties.sv ***
// Concurrent checks on the pin port
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_port_properties (
  input wire logic        mclk,              // Clock
  input wire logic        resetn,            // Async reset, active low
  input wire logic        s_axi_awvalid,     // Write address valid
  input wire logic        s_axi_awready,     // Write address ready
  input wire logic        s_axi_wvalid,      // Write data valid
  input wire logic        s_axi_wready,      // Write data ready
  input wire logic        s_axi_bvalid,      // Write response valid
  input wire logic        s_axi_bready,      // Write response ready
  input wire logic        s_axi_arvalid,     // Read address valid
  input wire logic        s_axi_arready,     // Read address ready
  input wire logic        s_axi_rvalid,      // Read data valid
  input wire logic        s_axi_rready,      // Read data ready
  input wire logic [15:0] general_pins_out,  // Pin drive values
  input wire logic [15:0] general_pins_oe_n, // Drive enable, low drives
  input wire logic [15:0] pin_gp_mode        // Pin owned by the port
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_own; (~general_pins_oe_n & ~pin_gp_mode) == 16'h0000; endproperty
  a_own: assert property (p_own) else $error("disabled pin driven");
  property p_out; (general_pins_out & ~pin_gp_mode) == 16'h0000; endproperty
  a_out: assert property (p_out) else $error("disabled pin has drive value");
  property p_rst; $rose(resetn) |-> pin_gp_mode == 16'h00f9 && general_pins_oe_n == 16'hffff; endproperty
  a_rst: assert property (p_rst) else $error("pin state after reset");
  property p_cfg; !$stable(general_pins_oe_n) |-> $rose(s_axi_bvalid); endproperty
  a_cfg: assert property (p_cfg) else $error("drive moved without write");
  property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer timing");
  property p_bend; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bend: assert property (p_bend) else $error("write answer held");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer timing");
  property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rend: assert property (p_rend) else $error("read answer held");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_drv: cover property (general_pins_oe_n != 16'hffff);
endmodule // gpio_pin_port_properties
`default_nettype wire

// *** verification/pin_partner.sv ***
// Outside circuit on the pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic [15:0] general_pins_oe_n, // Port drive enable, low drives
  input  wire logic [15:0] general_pins_out,  // Port drive values
  input  wire logic [15:0] ext,               // Outside circuit level
  output logic      [15:0] general_pins_in    // Resolved pin level
);
  // Outside circuit only drives pins the port released, so no contention
  assign general_pins_in = (general_pins_out & ~general_pins_oe_n) | (ext & general_pins_oe_n);
endmodule // pin_partner
`default_nettype wire

// *** verification/test_general_purpose_pin_port.sv ***
// Bench for the pin port
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_consts.svh"
module test_general_purpose_pin_port import gpio_pin_pkg::*; ;
  logic mclk = '0, resetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d, en, dir, dout;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  pin_vec_t general_pins_in, general_pins_out, general_pins_oe_n, pin_gp_mode, ext = '0, drv;
  int num_errors = 0, num_checks = 0, seed = 45;
  always #12.5 mclk = ~mclk;
  general_purpose_pin_port u_dut (.*);
  pin_partner u_far (.*);
  task automatic test_done(input bit hang);
    num_errors += hang;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
  endtask
  task automatic xfer(input bit w, input logic [31:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= {a, wd, a};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n >= 50) test_done(1'b1);
  endtask
  initial begin
    // Second pass resets with setup loaded, so reset must undo writes
    repeat (2) begin
      resetn <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      xfer(1'b0, `PIN_ENABLE_OFFSET, '0);
      chk("en rst", d, 32'h0000_00f9);
      xfer(1'b0, `PIN_DIRECTION_OFFSET, '0);
      chk("dir rst", d, 32'h0000_0000);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
        en = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hffff_ffff : $random(seed);
        dir = (i < 2) ? 32'hffff_ffff : $random(seed);
        dout = $random(seed);
        drv = en[15:0] & dir[15:0];
        ext <= 16'($random(seed));
        xfer(1'b1, `PIN_ENABLE_OFFSET, en);
        chk("en bresp", {30'h0000_0000, r}, 32'(`AXI_RESP_OKAY));
        xfer(1'b1, `PIN_DIRECTION_OFFSET, dir);
        chk("dir bresp", {30'h0000_0000, r}, 32'(`AXI_RESP_OKAY));
        xfer(1'b1, `PIN_DATA_OUT_OFFSET, dout);
        xfer(1'b0, `PIN_ENABLE_OFFSET, '0);
        chk("en", d, en & 32'h0000_ffff);
        chk("en rresp", {30'h0000_0000, r}, 32'(`AXI_RESP_OKAY));
        xfer(1'b0, `PIN_DIRECTION_OFFSET, '0);
        chk("dir", d, dir & 32'h0000_ffff);
        xfer(1'b0, `PIN_DATA_IN_OFFSET, '0);
        chk("level", d, {16'h0000, dout[15:0] & drv | ext & ~drv});
        chk("oe", {16'h0000, general_pins_oe_n}, {16'h0000, ~drv});
        chk("mode", {16'h0000, pin_gp_mode}, en & 32'h0000_ffff);
      end
      $display("random test done");
      // Only lane 1 is written, so the low enable byte must survive
      s_axi_wstrb <= 4'h2;
      xfer(1'b1, `PIN_ENABLE_OFFSET, 32'hffff_a55a);
      s_axi_wstrb <= 4'hf;
      xfer(1'b0, `PIN_ENABLE_OFFSET, '0);
      chk("en lane", d, {16'h0000, 8'ha5, en[7:0]});
      xfer(1'b1, `PIN_DATA_IN_OFFSET, 32'hffff_ffff);
      chk("in wr", {30'h0000_0000, r}, 32'(`AXI_RESP_OKAY));
      xfer(1'b1, 32'h01b0_0010, 32'hffff_ffff);
      chk("unmapped wr", {30'h0000_0000, r}, 32'(`AXI_RESP_SLVERR));
      xfer(1'b0, `PIN_DIRECTION_OFFSET, '0);
      chk("dir kept", d, dir & 32'h0000_ffff);
      $display("strobe test done");
      xfer(1'b0, 32'h01b0_0010, '0);
      chk("unmapped", {d[29:0], r}, 32'(`AXI_RESP_SLVERR));
      $display("unmapped test done");
    end
    test_done(1'b0);
  end
endmodule // test_general_purpose_pin_port
bind general_purpose_pin_port gpio_pin_port_properties u_props (.*);
`default_nettype wire
